/* bench/tb.sv */
// self-checking bench for the receive flag unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
    end end
module tb;
    import urfs_pkg::*;
    logic        mclk, rst_n, cyc, stb, we, ack, pA, pB, pC, irq;
    logic [7:0]  adr;
    logic [31:0] datI, datO;
    logic [1:0]  lineSt;
    logic        rxAct, rxErr;
    logic [4:0]  lastEp;
    urfs_pkt_s   pkt;
    urfs_rxep_s  rxEp;
    int          n_mismatch = 0;
    int          check_count = 0;
    urfs_unit urfs_unit_i (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .utmiRxActive(rxAct), .utmiRxError(rxErr), .utmiLineState(lineSt),
        .pktIn(pkt), .rxEpOut(rxEp), .flag_port_a(pA), .flag_port_b(pB),
        .flag_port_c(pC), .irq(irq));
    urfs_phy_model urfs_phy_model_i (.mclk(mclk), .rxEpOut(rxEp),
        .utmiRxActive(rxAct), .utmiRxError(rxErr), .utmiLineState(lineSt),
        .pktIn(pkt), .lastEp(lastEp));
    always #5 mclk = ~mclk;
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datI <= d;
        do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic ev(input urfs_pkt_s p);
        urfs_phy_model_i.pulse(p);
    endtask
    task automatic tToken;
        wr(OFF_DEVADDR, 32'h5);
        ev('{tokenOk: 1'b1, tokenEp: 4'h3, default: '0});
        rd(OFF_FLAGS, 32'h0);
        ev('{tokenOk: 1'b1, tokenAddr: 7'h05, tokenEp: 4'h3, default: '0});
        rd(OFF_FLAGS, 32'h40);
        rd(OFF_EP, 32'h13);
        `CHK(lastEp, 5'h03)
        wr(OFF_EPMARK, 32'h8);
        ev('{tokenOk: 1'b1, tokenAddr: 7'h05, tokenEp: 4'h3, default: '0});
        `CHK(lastEp, 5'h13)
        ev('{pktStart: 1'b1, default: '0});
        rd(OFF_FLAGS, 32'h0);
    endtask
    task automatic tSticky;
        wr(OFF_STICKY, 32'hFFFF_FFC0);
        rd(OFF_STICKY, 32'h40);
        ev('{tokenOk: 1'b1, tokenAddr: 7'h05, default: '0});
        ev('{pktStart: 1'b1, default: '0});
        rd(OFF_FLAGS, 32'h40);
        wr(OFF_FLAGS, 32'h40);
        rd(OFF_FLAGS, 32'h0);
        wr(OFF_STICKY, 32'h0);
    endtask
    task automatic tCrcIrq;
        wr(OFF_IRQEN, 32'h4);
        ev('{crc16Fail: 1'b1, default: '0});
        rd(OFF_FLAGS, 32'h4);
        `CHK(irq, 1'b1)
        wr(OFF_IRQCLR, 32'h4);
        `CHK(irq, 1'b0)
        wr(OFF_IRQEN, 32'h0);
        ev('{crc16Fail: 1'b1, default: '0});
        `CHK(irq, 1'b0)
        wr(OFF_IRQEN, 32'h4);
        `CHK(irq, 1'b1)
        wr(OFF_IRQCLR, 32'hF);
        `CHK(irq, 1'b0)
        ev('{pktStart: 1'b1, default: '0});
    endtask
    task automatic tRxPorts;
        urfs_phy_model_i.setRx(1'b1, 1'b1);
        rd(OFF_FLAGS, 32'h3);
        wr(OFF_PMASK, 32'h0004_0201);
        `CHK({pA, pB, pC}, 3'b110)
        urfs_phy_model_i.setRx(1'b0, 1'b0);
        rd(OFF_FLAGS, 32'h0);
        `CHK(pA, 1'b0)
    endtask
    task automatic tLine;
        urfs_phy_model_i.setLine(LS_K);
        rd(OFF_FLAGS, 32'h0);
        wr(OFF_CTRL, 32'h4);
        urfs_phy_model_i.setLine(LS_SE0);
        urfs_phy_model_i.setLine(LS_K);
        urfs_phy_model_i.setLine(LS_J);
        rd(OFF_FLAGS, 32'h38);
        wr(OFF_CTRL, 32'h0);
        ev('{pktStart: 1'b1, default: '0});
        rd(OFF_FLAGS, 32'h0);
    endtask
    task automatic tSofPid;
        wr(OFF_SOF, 32'hFFFF_FFFF);
        rd(OFF_SOF, 32'h7FF);
        ev('{sofValid: 1'b1, sofFrame: 11'h2A5, default: '0});
        rd(OFF_SOF, 32'h2A5);
        ev('{pidValid: 1'b1, pid: 4'hD, default: '0});
        rd(OFF_PID, 32'hD);
        wr(OFF_PID, 32'h0);
        rd(OFF_PID, 32'hD);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0);
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {mclk, rst_n, cyc, stb, we, adr, datI} = '0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFF_FLAGS, 32'h0);
        rd(OFF_PMASK, 32'h0);
        rd(OFF_EPMARK, 32'h0);
        tToken();
        tSticky();
        tCrcIrq();
        tRxPorts();
        tLine();
        tSofPid();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
endmodule
bind urfs_unit urfs_unit_props #(.NPORT(NPORT)) urfs_unit_props_i (.mclk,
    .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .utmiRxActive, .utmiRxError, .utmiLineState,
    .pktIn, .rxEpOut, .flag_port_a, .flag_port_b, .flag_port_c, .irq);
`default_nettype wire

/* bench/urfs_phy_model.sv */
// transceiver and packet decoder stand-in
`timescale 1ns/1ps
`default_nettype none
module urfs_phy_model
    import urfs_pkg::*;
(
    input  wire logic                 mclk,
    input  wire urfs_pkg::urfs_rxep_s rxEpOut,
    output logic                      utmiRxActive,
    output logic                      utmiRxError,
    output logic [1:0]                utmiLineState,
    output urfs_pkg::urfs_pkt_s       pktIn,
    output logic [4:0]                lastEp
);
    initial begin
        utmiRxActive = 1'b0;
        utmiRxError = 1'b0;
        utmiLineState = LS_J;
        pktIn = '0;
        lastEp = 5'h00;
    end
    task automatic pulse(input urfs_pkt_s p);
        pktIn <= p;
        @(posedge mclk);
        pktIn <= '0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic setLine(input logic [1:0] ls);
        utmiLineState <= ls;
        repeat (3) @(posedge mclk);
    endtask
    task automatic setRx(input logic act, input logic err);
        utmiRxActive <= act;
        utmiRxError <= err;
        repeat (3) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (rxEpOut.valid === 1'b1) lastEp <= rxEpOut.ep;
    end
endmodule
`default_nettype wire

/* bench/urfs_unit_props.sv */
// port-level checks of the receive flag unit
`timescale 1ns/1ps
`default_nettype none
module urfs_unit_props
    import urfs_pkg::*;
#(
    parameter int NPORT = 3
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                utmiRxActive,
    input wire logic                utmiRxError,
    input wire logic [1:0]          utmiLineState,
    input wire urfs_pkg::urfs_pkt_s pktIn,
    input wire urfs_pkg::urfs_rxep_s rxEpOut,
    input wire logic                flag_port_a,
    input wire logic                flag_port_b,
    input wire logic                flag_port_c,
    input wire logic                irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence sReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sAck;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ========================================
    // bus handshake
    a_ack_follows: assert property (sReq |=> sAck)
        else $error("ack not one cycle after request");
    a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
        else $error("ack rose without cycle");
    a_rdata_hold: assert property ($changed(wb_dat_o) |->
        $past(wb_cyc_i && wb_stb_i && !wb_we_i))
        else $error("read data moved without read");
    // ========================================
    // endpoint delivery, ports and interrupt
    a_ep_cause: assert property (rxEpOut.valid |-> $past(pktIn.tokenOk))
        else $error("endpoint out without token");
    a_ep_number: assert property (rxEpOut.valid |->
        rxEpOut.ep[3:0] == $past(pktIn.tokenEp))
        else $error("endpoint number wrong");
    a_port_fall: assert property ($fell(flag_port_a) |->
        $past(pktIn.pktStart || wb_we_i || !utmiRxActive || !utmiRxError))
        else $error("port a dropped without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wb_cyc_i && wb_we_i))
        else $error("interrupt dropped without write");
endmodule
`default_nettype wire

/* verilog/urfs_pkg.sv */
// package for the receive flag and status unit
package urfs_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFF_FLAGS   = 8'h1C;
    localparam logic [7:0] OFF_STICKY  = 8'h20;
    localparam logic [7:0] OFF_PMASK   = 8'h24;
    localparam logic [7:0] OFF_SOF     = 8'h28;
    localparam logic [7:0] OFF_PID     = 8'h2C;
    localparam logic [7:0] OFF_EP      = 8'h30;
    localparam logic [7:0] OFF_EPMARK  = 8'h34;
    localparam logic [7:0] OFF_OTGMASK = 8'h38;
    localparam logic [7:0] OFF_PWRSIG  = 8'h3C;
    localparam logic [7:0] OFF_CTRL    = 8'h04;
    localparam logic [7:0] OFF_DEVADDR = 8'h08;
    localparam logic [7:0] OFF_IRQST   = 8'h44;
    localparam logic [7:0] OFF_IRQEN   = 8'h48;
    localparam logic [7:0] OFF_IRQCLR  = 8'h4C;
    // ========================================
    // field layout
    localparam int NFLAG       = 7;
    localparam int FLG_TOKEN   = 6;
    localparam int FLG_SE0     = 5;
    localparam int FLG_K       = 4;
    localparam int FLG_J       = 3;
    localparam int FLG_CRC     = 2;
    localparam int FLG_RXACT   = 1;
    localparam int FLG_RXERR   = 0;
    localparam int CTRL_LSDEC  = 2;
    localparam int EP_VALID    = 4;
    localparam int PWR_VALID   = 8;
    localparam int SOF_W       = 11;
    localparam logic [4:0] EP_MARK_OR = 5'h10;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    // events: packet start, token, crc fail, linestate change
    localparam int NIRQ = 4;
    // ========================================
    // packet side inputs
    typedef struct packed {
        logic       pktStart;
        logic       tokenOk;
        logic [6:0] tokenAddr;
        logic [3:0] tokenEp;
        logic       pidValid;
        logic [3:0] pid;
        logic       crc16Fail;
        logic       sofValid;
        logic [10:0] sofFrame;
    } urfs_pkt_s;
    typedef struct packed {
        logic       valid;
        logic [4:0] ep;
    } urfs_rxep_s;
endpackage

/* verilog/urfs_unit.sv */
// receive flag, port mask and packet status unit with wishbone registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - non-sticky flags 6 to 2 clear when the next packet begins
// RULE2 - sticky flags hold until software writes one to the bit
// RULE3 - non-sticky flags 1 and 0 follow later changes of their signal
// RULE4 - bit 6 sets on a good token addressed to this device
// RULE5 - bits 5, 4, 3 set on SE0, K, J line states
// RULE6 - bit 2 sets when a data packet fails CRC16
// RULE7 - bit 1 follows rx active, bit 0 follows rx error
// RULE8 - each port output is the OR of its masked flags
// RULE9 - 11-bit frame counter readable and writable, split 10:8 and 7:0
// RULE10 - last received PID captured in a read-only field
// RULE11 - last endpoint stored with valid bit 4
// RULE12 - marked endpoints delivered on rx port ORed with 0x10
// RULE13 - tokens count only when matching programmed address, zero at reset
// RULE14 - line state flags only while decoder enable bit 2 is set
// RULE15 - hardware set wins over simultaneous software clear
// RULE16 - all fields reset to zero, reserved bits read zero
module urfs_unit #(
    parameter int NPORT = 3
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              utmiRxActive,
    input  wire logic              utmiRxError,
    input  wire logic [1:0]        utmiLineState,
    input  wire urfs_pkg::urfs_pkt_s pktIn,
    output urfs_pkg::urfs_rxep_s   rxEpOut,
    output logic                   flag_port_a,
    output logic                   flag_port_b,
    output logic                   flag_port_c,
    output logic                   irq
);
    import urfs_pkg::*;

    // ========================================
    // register state
    logic [NFLAG-1:0]  flags_q;
    logic [NFLAG-1:0]  sticky_q;
    logic [23:0]       pmask_q;
    logic [SOF_W-1:0]  sof_q;
    logic [3:0]        pid_q;
    logic [4:0]        ep_q;
    logic [15:0]       epMark_q;
    logic [31:0]       otgMask_q;
    logic [8:0]        pwrSig_q;
    logic [7:0]        ctrl_q;
    logic [6:0]        devAddr_q;
    logic [NIRQ-1:0]   irqSt_q;
    logic [NIRQ-1:0]   irqEn_q;
    logic [1:0]        lsPrev_q;

    // ========================================
    // bus decode
    logic        wrStb;
    logic [31:0] wrMask;

    assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    function automatic logic hit(input logic [7:0] off);
        hit = wrStb && (wb_adr_i == off);
    endfunction

    logic [31:0] wdFlags;
    assign wdFlags = wb_dat_i & wrMask;

    // merged write words; a call result cannot be sliced directly
    logic [31:0] sticky_d;
    logic [31:0] pmask_d;
    logic [31:0] epMark_d;
    logic [31:0] pwrSig_d;
    logic [31:0] ctrl_d;
    logic [31:0] devAddr_d;
    logic [31:0] irqEn_d;
    logic [31:0] sof_d;

    assign sticky_d  = merge({25'h0, sticky_q}, wb_dat_i, wrMask);
    assign pmask_d   = merge({8'h0, pmask_q}, wb_dat_i, wrMask);
    assign epMark_d  = merge({16'h0, epMark_q}, wb_dat_i, wrMask);
    assign pwrSig_d  = merge({23'h0, pwrSig_q}, wb_dat_i, wrMask);
    assign ctrl_d    = merge({24'h0, ctrl_q}, wb_dat_i, wrMask);
    assign devAddr_d = merge({25'h0, devAddr_q}, wb_dat_i, wrMask);
    assign irqEn_d   = merge({28'h0, irqEn_q}, wb_dat_i, wrMask);
    assign sof_d     = merge({21'h0, sof_q}, wb_dat_i, wrMask);

    // ========================================
    // flag events
    logic             tokMatch;
    logic [NFLAG-1:0] evSet;
    logic [NFLAG-1:0] level;
    logic             lsDecEn;

    assign lsDecEn = ctrl_q[CTRL_LSDEC];
    // RULE13 address match
    assign tokMatch = pktIn.tokenOk && (pktIn.tokenAddr == devAddr_q);

    always_comb begin
        evSet = '0;
        level = '0;
        // RULE4 token flag
        evSet[FLG_TOKEN] = tokMatch;
        // RULE14 decoder gate
        if (lsDecEn) begin
            // RULE5 line state symbols
            evSet[FLG_SE0] = (utmiLineState == LS_SE0);
            evSet[FLG_K]   = (utmiLineState == LS_K);
            evSet[FLG_J]   = (utmiLineState == LS_J);
        end
        // RULE6 crc16 failure
        evSet[FLG_CRC] = pktIn.crc16Fail;
        // RULE7 follow receiver inputs
        level[FLG_RXACT] = utmiRxActive;
        level[FLG_RXERR] = utmiRxError;
        evSet[FLG_RXACT] = utmiRxActive;
        evSet[FLG_RXERR] = utmiRxError;
    end

    // ========================================
    // flag register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= RESET_VAL[NFLAG-1:0];
        end else begin
            for (int i = 0; i < NFLAG; i++) begin
                if (sticky_q[i]) begin
                    // RULE15 set beats clear
                    // RULE2 hold until written one
                    if (evSet[i])
                        flags_q[i] <= 1'b1;
                    else if (hit(OFF_FLAGS) && wdFlags[i])
                        flags_q[i] <= 1'b0;
                end else if (i == FLG_RXACT || i == FLG_RXERR) begin
                    // RULE3 signal overwrites
                    flags_q[i] <= level[i];
                end else if (evSet[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (pktIn.pktStart) begin
                    // RULE1 clear on new packet
                    flags_q[i] <= 1'b0;
                end else if (hit(OFF_FLAGS) && wdFlags[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // ========================================
    // software registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sticky_q  <= '0;
            pmask_q   <= '0;
            epMark_q  <= '0;
            otgMask_q <= RESET_VAL;
            pwrSig_q  <= '0;
            ctrl_q    <= '0;
            devAddr_q <= '0;
            irqEn_q   <= '0;
        end else begin
            // RULE16 reserved bits dropped
            if (hit(OFF_STICKY))
                sticky_q <= sticky_d[NFLAG-1:0];
            if (hit(OFF_PMASK))
                pmask_q <= pmask_d[23:0];
            if (hit(OFF_EPMARK))
                epMark_q <= epMark_d[15:0];
            if (hit(OFF_OTGMASK))
                otgMask_q <= merge(otgMask_q, wb_dat_i, wrMask);
            if (hit(OFF_PWRSIG))
                pwrSig_q <= pwrSig_d[8:0];
            if (hit(OFF_CTRL))
                ctrl_q <= ctrl_d[7:0];
            // RULE13 software loads address
            if (hit(OFF_DEVADDR))
                devAddr_q <= devAddr_d[6:0];
            if (hit(OFF_IRQEN))
                irqEn_q <= irqEn_d[NIRQ-1:0];
        end
    end

    // ========================================
    // packet status capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sof_q <= '0;
        end else if (pktIn.sofValid) begin
            sof_q <= pktIn.sofFrame;
        end else if (hit(OFF_SOF)) begin
            // RULE9 software write of count
            sof_q <= sof_d[SOF_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pid_q <= '0;
        end else if (pktIn.pidValid) begin
            // RULE10 last pid
            pid_q <= pktIn.pid;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ep_q <= '0;
        end else if (tokMatch) begin
            // RULE11 endpoint and valid
            ep_q <= {1'b1, pktIn.tokenEp};
        end
    end

    // RULE12 marked endpoint delivery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxEpOut <= '0;
        end else begin
            rxEpOut.valid <= tokMatch;
            if (tokMatch)
                rxEpOut.ep <= epMark_q[pktIn.tokenEp]
                              ? ({1'b0, pktIn.tokenEp} | EP_MARK_OR)
                              : {1'b0, pktIn.tokenEp};
        end
    end

    // ========================================
    // port outputs
    // RULE8 masked or per port
    assign flag_port_a = |(flags_q & pmask_q[6:0]);
    assign flag_port_b = |(flags_q & pmask_q[14:8]);
    assign flag_port_c = |(flags_q & pmask_q[22:16]);

    // ========================================
    // interrupts
    logic [NIRQ-1:0] irqEv;
    logic [NIRQ-1:0] irqClr;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            lsPrev_q <= '0;
        else
            lsPrev_q <= utmiLineState;
    end

    assign irqEv = {lsDecEn && (lsPrev_q != utmiLineState),
                    pktIn.crc16Fail, tokMatch, pktIn.pktStart};
    assign irqClr = hit(OFF_IRQCLR) ? wdFlags[NIRQ-1:0] : '0;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            irqSt_q <= '0;
        else
            // set wins over write-one clear
            irqSt_q <= (irqSt_q & ~irqClr) | irqEv;
    end

    assign irq = |(irqSt_q & irqEn_q);

    // ========================================
    // read path, one wait-free cycle answer
    logic [31:0] rdData;

    always_comb begin
        rdData = '0;
        unique case (wb_adr_i)
            OFF_FLAGS:   rdData = {25'h0, flags_q};
            OFF_STICKY:  rdData = {25'h0, sticky_q};
            OFF_PMASK:   rdData = {8'h0, pmask_q};
            OFF_SOF:     rdData = {21'h0, sof_q};
            OFF_PID:     rdData = {28'h0, pid_q};
            OFF_EP:      rdData = {27'h0, ep_q};
            OFF_EPMARK:  rdData = {16'h0, epMark_q};
            OFF_OTGMASK: rdData = otgMask_q;
            OFF_PWRSIG:  rdData = {23'h0, pwrSig_q};
            OFF_CTRL:    rdData = {24'h0, ctrl_q};
            OFF_DEVADDR: rdData = {25'h0, devAddr_q};
            OFF_IRQST:   rdData = {28'h0, irqSt_q};
            OFF_IRQEN:   rdData = {28'h0, irqEn_q};
            default:     rdData = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            // unmapped addresses still ack, reading zero
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
                wb_dat_o <= rdData;
        end
    end
endmodule
`default_nettype wire
